// ===== hw/bmr_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module bmr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   // fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } bmr_fifo_st_t;
   bmr_fifo_st_t q;
   bmr_fifo_st_t next_q;
   logic         push;
   logic         pop;
   // ==========================================================================
   // honest flags straight from the count
   assign o_in_ready  = (q.cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (q.cnt != '0);
   assign o_out_data  = q.mem[q.rd];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   // next state
   always_comb begin
      next_q = q;
      if (push) begin
         next_q.mem[q.wr] = i_in_data;
         next_q.wr        = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         next_q.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
      end
      next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   // registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= next_q;
      end
   end
endmodule : bmr_fifo

// ===== hw/bmr_pkg.sv
// shared constants and types of the broadcast message receiver
package bmr_pkg;
   // ==========================================================================
   // widths and depths
   localparam int MSG_W       = 8;     // one message byte
   localparam int CH0_DEPTH   = 8;     // channel 0 queue entries
   localparam int BUF_DEPTH   = 32;    // ingress buffer words
   localparam int BOARD_MAX   = 20;    // boards one write can reach
   localparam int ADDR_W      = 31;    // bus address lines 31..1
   // ==========================================================================
   // broadcast address layout (addr index n holds bus line n+1)
   localparam logic [7:0] BCAST_BASE = 8'hFA;  // upper address byte of the area
   localparam int BASE_LSB    = 23;    // bus line 24
   localparam int CH_BIT      = 0;     // bus line 1 picks the channel
   localparam int MASK_LSB    = 1;     // bus lines 2..21, one per board
   localparam int SLOT_W      = 5;
   // ==========================================================================
   // reset values
   localparam logic [2:0] LVL_NONE = 3'h0;  // no request on the local line
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // ==========================================================================
   // bus slave states, one-hot
   typedef enum logic [2:0] {
      BMR_IDLE = 3'b001,
      BMR_ACK  = 3'b010,
      BMR_HOLD = 3'b100
   } bmr_state_t;
   // sampled bus pins
   typedef struct packed {
      logic              as_n;
      logic              ds_n;
      logic              write_n;
      logic [ADDR_W-1:0] addr;
      logic [MSG_W-1:0]  data;
      logic [SLOT_W-1:0] slot;
   } bmr_bus_t;
   // message handed to the local side
   typedef struct packed {
      logic             valid;
      logic [MSG_W-1:0] data;
   } bmr_msg_t;
endpackage : bmr_pkg

// ===== hw/bmr_top.sv
// broadcast message receiver: bus write capture, two message channels, local requests
`timescale 1ns/1ps
// Summary of operation
// - a message arrives as one plain bus write cycle, answered with an ordinary data acknowledge.
// - one write reaches every board whose bit is set in the twenty-bit board field of the address.
// - a selected board stores the message and raises its local request at the chosen level.
// - the two channels keep separate storage, status and request logic.
// - channel 0 queues messages forty deep in arrival order: eight queue entries fed from the 32-word ingress buffer.
// - channel 1 holds a single message, the newest one written.
// - each channel's request level is set by software from 1 to 7, 0 leaving it silent.
module bmr_top (
   // clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_rst,
   input  wire logic                          i_ce,
   // bus pins
   input  wire logic                          i_vme_as_n,
   input  wire logic                          i_vme_ds_n,
   input  wire logic                          i_vme_write_n,
   input  wire logic [bmr_pkg::ADDR_W-1:0]    i_vme_addr,
   input  wire logic [bmr_pkg::MSG_W-1:0]     i_vme_data,
   output logic                               o_vme_dtack_n_o,
   output logic                               o_vme_dtack_n_oe,
   // board slot strap, 0..19
   input  wire logic [bmr_pkg::SLOT_W-1:0]    i_slot,
   // local side
   input  wire logic [2:0]                    i_lvl0,
   input  wire logic [2:0]                    i_lvl1,
   input  wire logic                          i_rd0,
   input  wire logic                          i_rd1,
   output bmr_pkg::bmr_msg_t                  o_msg0,
   output bmr_pkg::bmr_msg_t                  o_msg1,
   output logic [2:0]                         o_irq0_lvl,
   output logic [2:0]                         o_irq1_lvl
);
   typedef struct packed {
      bmr_pkg::bmr_bus_t                                         s1;
      bmr_pkg::bmr_bus_t                                         s2;
      bmr_pkg::bmr_state_t                                       st;
      logic                                                      dtack;
      logic [bmr_pkg::CH0_DEPTH-1:0][bmr_pkg::MSG_W-1:0]         mem0;
      logic [2:0]                                                wr0;
      logic [2:0]                                                rd0;
      logic [3:0]                                                cnt0;
      logic                                                      full1;
      logic [bmr_pkg::MSG_W-1:0]                                 msg1;
      bmr_pkg::bmr_msg_t                                         out0;
      bmr_pkg::bmr_msg_t                                         out1;
      logic [2:0]                                                irq0;
      logic [2:0]                                                irq1;
   } bmr_st_t;

   bmr_st_t                    q;
   bmr_st_t                    next_q;
   bmr_pkg::bmr_bus_t          pins;
   logic                       hit;
   logic                       sel;
   logic                       cycle;
   logic                       cap0;
   logic                       cap1;
   logic                       buf_ready;
   logic                       buf_valid;
   logic [bmr_pkg::MSG_W-1:0]  buf_data;
   logic                       push0;
   logic                       pop0;

   // ==========================================================================
   // board selection from the address
   function automatic logic board_hit(input logic [bmr_pkg::ADDR_W-1:0] a,
                                      input logic [bmr_pkg::SLOT_W-1:0] s);
      logic [bmr_pkg::BOARD_MAX-1:0] mask;
      mask = a[bmr_pkg::MASK_LSB +: bmr_pkg::BOARD_MAX];
      return (s < bmr_pkg::SLOT_W'(bmr_pkg::BOARD_MAX)) && mask[s];
   endfunction : board_hit

   assign pins = '{as_n: i_vme_as_n, ds_n: i_vme_ds_n, write_n: i_vme_write_n,
                   addr: i_vme_addr, data: i_vme_data, slot: i_slot};

   // decode on the second sync stage only
   assign cycle = !q.s2.as_n && !q.s2.ds_n && !q.s2.write_n;
   assign hit   = cycle && (q.s2.addr[bmr_pkg::BASE_LSB +: 8] == bmr_pkg::BCAST_BASE);
   assign sel   = hit && board_hit(q.s2.addr, q.s2.slot);
   // channel 0 waits for buffer room, which holds off the acknowledge
   assign cap0  = (q.st == bmr_pkg::BMR_IDLE) && sel && !q.s2.addr[bmr_pkg::CH_BIT] && buf_ready;
   assign cap1  = (q.st == bmr_pkg::BMR_IDLE) && sel && q.s2.addr[bmr_pkg::CH_BIT];
   // queue drains the buffer only while it has room
   assign push0 = buf_valid && (q.cnt0 != 4'(bmr_pkg::CH0_DEPTH));
   assign pop0  = i_rd0 && (q.cnt0 != bmr_pkg::CNT_ZERO);

   // ==========================================================================
   // ingress buffer in the channel 0 path
   bmr_fifo #(
      .WIDTH(bmr_pkg::MSG_W),
      .DEPTH(bmr_pkg::BUF_DEPTH)
   ) u_buf (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .i_in_valid (cap0),
      .o_in_ready (buf_ready),
      .i_in_data  (q.s2.data),
      .o_out_valid(buf_valid),
      .i_out_ready(push0),
      .o_out_data (buf_data)
   );

   // ==========================================================================
   // next state
   always_comb begin
      next_q      = q;
      next_q.s1   = pins;
      next_q.s2   = q.s1;
      // bus slave: one acknowledge per write cycle
      case (q.st)
         bmr_pkg::BMR_IDLE: begin
            if (cap0 || cap1) begin
               next_q.st    = bmr_pkg::BMR_ACK;
               next_q.dtack = 1'b1;
            end
         end
         bmr_pkg::BMR_ACK: begin
            if (q.s2.ds_n) begin
               next_q.st    = bmr_pkg::BMR_HOLD;
               next_q.dtack = 1'b0;
            end
         end
         bmr_pkg::BMR_HOLD: begin
            // one idle cycle so the same strobe never counts twice
            next_q.st = bmr_pkg::BMR_IDLE;
         end
         default: begin
            next_q.st    = bmr_pkg::BMR_IDLE;
            next_q.dtack = 1'b0;
         end
      endcase
      // channel 0 queue
      next_q.out0.valid = pop0;
      if (pop0) begin
         next_q.out0.data = q.mem0[q.rd0];
         next_q.rd0       = q.rd0 + 3'h1;
      end
      if (push0) begin
         next_q.mem0[q.wr0] = buf_data;
         next_q.wr0         = q.wr0 + 3'h1;
      end
      next_q.cnt0 = q.cnt0 + 4'(push0) - 4'(pop0);
      // channel 1 single slot: a fresh message beats a read in the same cycle
      next_q.out1.valid = i_rd1 && q.full1;
      if (i_rd1 && q.full1) begin
         next_q.out1.data = q.msg1;
         next_q.full1     = 1'b0;
      end
      if (cap1) begin
         next_q.msg1  = q.s2.data;
         next_q.full1 = 1'b1;
      end
      // separate request per channel, level 0 keeps it silent
      next_q.irq0 = (next_q.cnt0 != bmr_pkg::CNT_ZERO) ? i_lvl0 : bmr_pkg::LVL_NONE;
      next_q.irq1 = next_q.full1 ? i_lvl1 : bmr_pkg::LVL_NONE;
   end

   // registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q      <= '0;
         q.st   <= bmr_pkg::BMR_IDLE;
         q.s1   <= '1;
         q.s2   <= '1;
      end else if (i_ce) begin
         q <= next_q;
      end
   end

   // outputs straight from flops; acknowledge pin is only ever pulled low
   assign o_vme_dtack_n_o  = 1'b0;
   assign o_vme_dtack_n_oe = q.dtack;
   assign o_msg0           = q.out0;
   assign o_msg1           = q.out1;
   assign o_irq0_lvl       = q.irq0;
   assign o_irq1_lvl       = q.irq1;

   // ==========================================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_ce);

   a_ack_release: assert property ((q.st == bmr_pkg::BMR_ACK) && q.s2.ds_n |=>
      (q.st == bmr_pkg::BMR_HOLD) && !o_vme_dtack_n_oe ##1 (q.st == bmr_pkg::BMR_IDLE))
      else $error("acknowledge not released after strobe");
   a_unsel_quiet: assert property ((q.st == bmr_pkg::BMR_IDLE) && hit && !sel |=>
      (q.st == bmr_pkg::BMR_IDLE) && !o_vme_dtack_n_oe)
      else $error("unselected board answered");
   a_ch1_capture: assert property (cap1 |=> q.full1 && (q.msg1 == $past(q.s2.data)) &&
      (o_irq1_lvl == $past(i_lvl1)))
      else $error("channel 1 message or request missing");
   a_ack_take: assert property ((cap0 || cap1) |=>
      (q.st == bmr_pkg::BMR_ACK) && o_vme_dtack_n_oe)
      else $error("accepted write not acknowledged");
   a_ack_stand: assert property ((q.st == bmr_pkg::BMR_ACK) && !q.s2.ds_n |=>
      (q.st == bmr_pkg::BMR_ACK) && o_vme_dtack_n_oe)
      else $error("acknowledge dropped while strobe low");
   a_ch0_take: assert property (cap0 |=> buf_valid)
      else $error("channel 0 capture lost");
   // a full queue must hold its count, never drop or overwrite an entry
   a_ch0_full: assert property ((q.cnt0 == 4'(bmr_pkg::CH0_DEPTH)) && !i_rd0 |=>
      (q.cnt0 == 4'(bmr_pkg::CH0_DEPTH)))
      else $error("full channel 0 queue changed without a read");
   a_ch0_bound: assert property (q.cnt0 <= 4'(bmr_pkg::CH0_DEPTH))
      else $error("channel 0 queue overfilled");
   a_ch1_alone: assert property (cap1 && !push0 && !pop0 |=> $stable(q.cnt0))
      else $error("channel 1 write touched channel 0");
   a_lvl_follow: assert property ((q.cnt0 != bmr_pkg::CNT_ZERO) |=>
      (o_irq0_lvl == $past(i_lvl0)) || ($past(pop0) && $past(q.cnt0) == 4'h1))
      else $error("channel 0 request level wrong");
   a_read_pop: assert property (pop0 && !push0 |=> o_msg0.valid &&
      (q.cnt0 == $past(q.cnt0) - 4'h1) && (o_msg0.data == $past(q.mem0[q.rd0])))
      else $error("read did not remove oldest message");
   a_irq_drop: assert property ((q.cnt0 == bmr_pkg::CNT_ZERO) && !buf_valid |=>
      (o_irq0_lvl == bmr_pkg::LVL_NONE))
      else $error("request left up with empty queue");
   a_ch1_read: assert property (i_rd1 && q.full1 && !cap1 |=> !q.full1 && o_msg1.valid &&
      (o_irq1_lvl == bmr_pkg::LVL_NONE))
      else $error("channel 1 read did not empty slot");
endmodule : bmr_top

// ===== verification/bmr_master.sv
// bus master partner model issuing single broadcast write cycles
`timescale 1ns/1ps
module bmr_master (
   // clock and answer line
   input  wire logic        i_clk,
   input  wire logic        i_dtack_n,
   // bus pins
   output logic             o_as_n,
   output logic             o_ds_n,
   output logic             o_write_n,
   output logic [30:0]      o_addr,
   output logic [7:0]       o_data
);
   // ==========================================
   // idle bus at time zero
   initial begin
      o_as_n    = 1'b1;
      o_ds_n    = 1'b1;
      o_write_n = 1'b1;
      o_addr    = 31'h0;
      o_data    = 8'h0;
   end

   // one plain write cycle; ok stays low when nobody answers or the answer never ends
   task automatic write(input logic [30:0] a, input logic [7:0] d, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge i_clk);
      o_addr    <= a;
      o_data    <= d;
      o_write_n <= 1'b0;
      o_as_n    <= 1'b0;
      o_ds_n    <= 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge i_clk);
         #1 ok = !i_dtack_n;
      end
      @(posedge i_clk);
      o_as_n    <= 1'b1;
      o_ds_n    <= 1'b1;
      o_write_n <= 1'b1;
      o_addr    <= ~a;     // released lines must not keep the old value
      o_data    <= ~d;
      for (n = 0; n < 20 && !i_dtack_n; n++) begin
         @(posedge i_clk);
         #1;
      end
      ok = ok && i_dtack_n;   // a stuck acknowledge is a failed cycle
      @(posedge i_clk);
   endtask : write
endmodule : bmr_master

// ===== verification/bmr_top_tb.sv
// self-checking bench of the broadcast message receiver
`timescale 1ns/1ps
module bmr_top_tb;
   localparam logic [19:0] ME = 20'h80000;  // board in slot 19, the top slot
   logic              clk, rst, ce, rd0, rd1, as_n, ds_n, wr_n, oe, dq;
   logic [2:0]        lvl0, lvl1, irq0, irq1;
   logic [30:0]       addr;
   logic [7:0]        data;
   bmr_pkg::bmr_msg_t msg0, msg1;
   int                fails, comparisons;
   wire               dtack_n = oe ? dq : 1'b1;  // open drain with pull-up

   bmr_master u_mst (.i_clk(clk), .i_dtack_n(dtack_n), .o_as_n(as_n), .o_ds_n(ds_n),
      .o_write_n(wr_n), .o_addr(addr), .o_data(data));
   bmr_top u_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_vme_as_n(as_n), .i_vme_ds_n(ds_n),
      .i_vme_write_n(wr_n), .i_vme_addr(addr), .i_vme_data(data), .o_vme_dtack_n_o(dq),
      .o_vme_dtack_n_oe(oe), .i_slot(5'h13), .i_lvl0(lvl0), .i_lvl1(lvl1), .i_rd0(rd0),
      .i_rd1(rd1), .o_msg0(msg0), .o_msg1(msg1), .o_irq0_lvl(irq0), .o_irq1_lvl(irq1));

   // ==========================================
   // clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic logic [30:0] ba(logic [7:0] base, logic [19:0] mask, logic ch);
      return {base, 2'b00, mask, ch};
   endfunction : ba

   // write, judge the answer, then let the message settle
   task automatic wr(input logic [30:0] a, input logic [7:0] d, input logic exp);
      logic ok;
      u_mst.write(a, d, ok);
      check("answer", 8'(ok), 8'(exp));
      if (exp && !ok) results;
      repeat (3) @(posedge clk);
   endtask : wr

   task automatic rd(input logic ch, output logic v, output logic [7:0] d);
      @(posedge clk);
      if (ch) rd1 <= 1'b1;
      else rd0 <= 1'b1;
      @(posedge clk);
      rd0 <= 1'b0;
      rd1 <= 1'b0;
      #1 v = ch ? msg1.valid : msg0.valid;
      d = ch ? msg1.data : msg0.data;
   endtask : rd

   // fill queue and buffer until refused, drain in order
   task automatic t_queue;
      logic v;
      logic [7:0] d;
      for (int i = 0; i < 40; i++) wr(ba(8'hFA, ME | 20'h1, 1'b0), 8'h40 + 8'(i), 1'b1);
      wr(ba(8'hFA, ME, 1'b0), 8'hEE, 1'b0);
      check("irq1", 8'(irq1), 8'h0);
      for (int i = 0; i < 40; i++) begin
         repeat (3) @(posedge clk);
         check("irq0", 8'(irq0), 8'(lvl0));
         rd(1'b0, v, d);
         check("valid0", 8'(v), 8'h1);
         check("data0", d, 8'h40 + 8'(i));
      end
      check("irq0", 8'(irq0), 8'h0);
      rd(1'b0, v, d);
      check("empty0", 8'(v), 8'h0);
   endtask : t_queue

   // channel 1 keeps only the newest message
   task automatic t_single;
      logic v;
      logic [7:0] d;
      wr(ba(8'hFA, ME, 1'b1), 8'hA5, 1'b1);
      wr(ba(8'hFA, 20'hFFFFF, 1'b1), 8'h5A, 1'b1);
      check("irq1", 8'(irq1), 8'(lvl1));
      check("irq0", 8'(irq0), 8'h0);
      rd(1'b1, v, d);
      check("valid1", 8'(v), 8'h1);
      check("data1", d, 8'h5A);
      check("irq1", 8'(irq1), 8'h0);
      rd(1'b1, v, d);
      check("empty1", 8'(v), 8'h0);
   endtask : t_single

   // other boards and other areas are ignored
   task automatic t_select;
      wr(ba(8'hFA, 20'h7FFFF, 1'b0), 8'h11, 1'b0);
      wr(ba(8'hFB, ME, 1'b1), 8'h22, 1'b0);
      check("irq0", 8'(irq0), 8'h0);
      check("irq1", 8'(irq1), 8'h0);
   endtask : t_select

   // clock enable freezes everything; a reset in mid-run empties both channels
   task automatic t_freeze;
      logic v;
      logic [7:0] d;
      wr(ba(8'hFA, ME, 1'b1), 8'h3C, 1'b1);
      wr(ba(8'hFA, ME, 1'b0), 8'hC3, 1'b1);
      ce <= 1'b0;
      rd(1'b1, v, d);
      check("frozen1", 8'(v), 8'h0);
      check("irq1", 8'(irq1), 8'(lvl1));
      wr(ba(8'hFA, ME, 1'b1), 8'h99, 1'b0);
      ce <= 1'b1;
      rd(1'b1, v, d);
      check("valid1", 8'(v), 8'h1);
      check("data1", d, 8'h3C);
      rd(1'b0, v, d);
      check("valid0", 8'(v), 8'h1);
      check("data0", d, 8'hC3);
      wr(ba(8'hFA, ME, 1'b1), 8'h77, 1'b1);
      wr(ba(8'hFA, ME, 1'b0), 8'h88, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(1'b1, v, d);
      check("reset1", 8'(v), 8'h0);
      check("resetdata1", d, 8'h00);
      check("irq1", 8'(irq1), 8'h0);
      rd(1'b0, v, d);
      check("reset0", 8'(v), 8'h0);
      check("irq0", 8'(irq0), 8'h0);
   endtask : t_freeze

   // every request level on both channels, 0 silent
   task automatic t_levels;
      logic v;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         lvl0 <= 3'(i);
         lvl1 <= 3'(7 - i);
         @(posedge clk);
         wr(ba(8'hFA, ME, 1'b0), 8'(i), 1'b1);
         wr(ba(8'hFA, ME, 1'b1), 8'(i) + 8'h80, 1'b1);
         check("irq0", 8'(irq0), 8'(i));
         check("irq1", 8'(irq1), 8'(7 - i));
         rd(1'b0, v, d);
         check("data0", d, 8'(i));
         rd(1'b1, v, d);
         check("data1", d, 8'(i) + 8'h80);
      end
   endtask : t_levels

   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      rd0 = 1'b0;
      rd1 = 1'b0;
      lvl0 = 3'h3;
      lvl1 = 3'h6;
      fails = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_queue;
      t_single;
      t_select;
      t_freeze;
      t_levels;
      results;
   end
endmodule : bmr_top_tb
